// >>> bench/dca_arbiter_props.sv
// Concurrent checks on the ports of the access channel arbiter.
// Assumes one sys_clk domain and the asynchronous active-high rst.
`timescale 1ns/10ps
`include "dca_cfg.svh"
module dca_arbiter_props #(
   parameter int NPIN = 4,
   parameter int DW   = 16
) (
   input wire logic                          sys_clk,
   input wire logic                          rst,
   input wire logic                          fbWrEn,
   input wire logic                          fbRdEn,
   input wire logic [15:0]                   fbAddr,
   input wire logic [DW-1:0]                 fbWrData,
   input wire logic [DW-1:0]                 fbRdData,
   input wire logic                          fbAck,
   input wire logic                          fbErr,
   input wire logic                          commCmdValid,
   input wire logic                          fbRefValid,
   input wire logic [31:0]                   fbRef,
   input wire dca_pkg::dca_mode_t            opMode,
   input wire logic [NPIN-1:0]               sigPin,
   input wire dca_pkg::dca_func_t [NPIN-1:0] sigFunc,
   input wire logic                          safeTorqueOffA,
   input wire logic                          cmdValid,
   input wire dca_pkg::dca_owner_t           cmdSrc,
   input wire logic                          cmdRejected,
   input wire dca_pkg::dca_owner_t           owner,
   input wire logic                          channelLock,
   input wire logic                          haltActive,
   input wire logic                          powerRemovalA,
   input wire dca_pkg::dca_loop_t            loopSel,
   input wire logic                          refValid,
   input wire logic [31:0]                   refValue
);
   import dca_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Parameter accesses split into mapped and unmapped
   wire mapAcc = (fbWrEn | fbRdEn) & (fbAddr == `DCA_LOCK_ADDR);
   wire badAcc = (fbWrEn | fbRdEn) & (fbAddr != `DCA_LOCK_ADDR);
   sequence s_lockWrite;
      fbWrEn && fbAddr == `DCA_LOCK_ADDR ##1 fbAck;
   endsequence
   property p_ack; mapAcc |=> fbAck && !fbErr; endproperty
   property p_err; badAcc |=> fbErr && !fbAck && fbRdData == '0; endproperty
   property p_lock;
      s_lockWrite |-> channelLock == $past(fbWrData[0], 1);
   endproperty
   property p_own; channelLock |=> owner == `DCA_OWN_FB; endproperty
   property p_excl;
      owner == `DCA_OWN_FB && commCmdValid
         |=> cmdRejected && cmdSrc != `DCA_OWN_COMM;
   endproperty
   property p_comm;
      owner == `DCA_OWN_COMM && commCmdValid
         |=> cmdValid && cmdSrc == `DCA_OWN_COMM;
   endproperty
   property p_sto; $fell(safeTorqueOffA) |-> ##[1:6] powerRemovalA; endproperty
   property p_halt;
      $rose(sigPin[0]) && sigFunc[0] == `DCA_FN_HALT |-> ##[1:6] haltActive;
   endproperty
   property p_speed;
      opMode == MODE_SPEED |=> loopSel.velLoop && !loopSel.profGen;
   endproperty
   property p_pos;
      opMode inside {MODE_JOG, MODE_PPOS, MODE_PVEL, MODE_HOME}
         |=> loopSel.posLoop && loopSel.profGen && loopSel.refFieldbus;
   endproperty
   property p_ref;
      fbRefValid && loopSel.refFieldbus
         |=> refValid && refValue == $past(fbRef, 1);
   endproperty
   a_ack: assert property (p_ack)
      else $error("mapped access without acknowledge");
   a_err: assert property (p_err)
      else $error("unmapped access without error");
   a_lock: assert property (p_lock)
      else $error("lock register not written");
   a_own: assert property (p_own)
      else $error("lock set but fieldbus not owner");
   a_excl: assert property (p_excl)
      else $error("software command passed under lock");
   a_comm: assert property (p_comm)
      else $error("software owner command not granted");
   a_sto: assert property (p_sto)
      else $error("torque off not signalled");
   a_halt: assert property (p_halt)
      else $error("halt pin not effective");
   a_speed: assert property (p_speed)
      else $error("speed mode routing wrong");
   a_pos: assert property (p_pos)
      else $error("position mode routing wrong");
   a_ref: assert property (p_ref)
      else $error("reference not taken");
endmodule // dca_arbiter_props
bind dca_arbiter dca_arbiter_props #(.NPIN(NPIN), .DW(DW)) u_props (
   .sys_clk(sys_clk), .rst(rst), .fbWrEn(fbWrEn), .fbRdEn(fbRdEn),
   .fbAddr(fbAddr), .fbWrData(fbWrData), .fbRdData(fbRdData),
   .fbAck(fbAck), .fbErr(fbErr), .commCmdValid(commCmdValid),
   .fbRefValid(fbRefValid), .fbRef(fbRef), .opMode(opMode),
   .sigPin(sigPin), .sigFunc(sigFunc), .safeTorqueOffA(safeTorqueOffA),
   .cmdValid(cmdValid), .cmdSrc(cmdSrc), .cmdRejected(cmdRejected),
   .owner(owner), .channelLock(channelLock), .haltActive(haltActive),
   .powerRemovalA(powerRemovalA), .loopSel(loopSel),
   .refValid(refValid), .refValue(refValue));

// >>> bench/dca_far_model.sv
// Local switch inputs and the external safety circuit.
// Assumes the bench sets levels; pins are asynchronous to sys_clk.
`timescale 1ns/10ps
module dca_far_model (
   input  wire logic       stoOff,
   input  wire logic [3:0] sigLevel,
   output logic [3:0]      sigPin,
   output logic            safeTorqueOffA,
   output logic            safeTorqueOffB
);
   // Controller side keeps automatic power enable off around torque off
   localparam logic AUTO_POWER_ENABLE = 1'b0;
   // Switch contacts drive the configurable pins
   assign sigPin = sigLevel;
   // Safety circuit drops both channels together, low removes torque
   assign safeTorqueOffA = !stoOff;
   assign safeTorqueOffB = !stoOff;
endmodule // dca_far_model

// >>> bench/tb_top.sv
// Self-checking bench of the access channel arbiter.
// Assumes dca_pkg and dca_cfg.svh compiled; inputs change on falling edge.
`timescale 1ns/10ps
`include "dca_cfg.svh"
module tb_top;
   import dca_pkg::*;
   logic sys_clk = 0, rst = 1, fbWrEn = 0, fbRdEn = 0, fbCmdValid = 0;
   logic fbRefValid = 0, commAccess = 0, commCmdValid = 0, stoOff = 0;
   logic nvLoad = 0, nvLock = 0;
   logic [15:0] fbAddr = '0, fbWrData = '0, fbRdData;
   logic [31:0] fbRef = '0, refValue;
   logic [3:0]  sigLevel = '0, sigPin;
   logic fbAck, fbErr, cmdValid, cmdRejected, channelLock, haltActive;
   logic posLim, negLim, refSw, prA, prB, torqueOff, refValid, stoA, stoB;
   dca_cmd_t   fbCmd = '{code: `DCA_CMD_ENABLE, arg: 16'h0001};
   dca_cmd_t   commCmd = '{code: `DCA_CMD_QSTOP, arg: 16'h0002};
   dca_cmd_t   cmdOut;
   dca_owner_t cmdSrc, owner;
   dca_mode_t  opMode = MODE_NONE;
   dca_loop_t  loopSel;
   dca_func_t [3:0] sigFunc = {`DCA_FN_REF, `DCA_FN_POSITIVE_LIMIT_SWITCH,
                               `DCA_FN_ENABLE, `DCA_FN_HALT};
   int bad_count = 0, total_checks = 0;
   always #2.5 sys_clk = ~sys_clk;
   dca_far_model far (.stoOff(stoOff), .sigLevel(sigLevel), .sigPin(sigPin),
      .safeTorqueOffA(stoA), .safeTorqueOffB(stoB));
   dca_arbiter uut (.sys_clk(sys_clk), .rst(rst), .fbWrEn(fbWrEn),
      .fbRdEn(fbRdEn), .fbAddr(fbAddr), .fbWrData(fbWrData),
      .fbRdData(fbRdData), .fbAck(fbAck), .fbErr(fbErr), .nvLoad(nvLoad),
      .nvLock(nvLock), .fbCmdValid(fbCmdValid), .fbCmd(fbCmd),
      .fbRefValid(fbRefValid), .fbRef(fbRef), .opMode(opMode),
      .commAccess(commAccess), .commCmdValid(commCmdValid),
      .commCmd(commCmd), .sigPin(sigPin), .sigFunc(sigFunc),
      .safeTorqueOffA(stoA), .safeTorqueOffB(stoB), .cmdValid(cmdValid),
      .cmdOut(cmdOut), .cmdSrc(cmdSrc), .cmdRejected(cmdRejected),
      .owner(owner), .channelLock(channelLock), .haltActive(haltActive),
      .positiveLimitSwitch(posLim), .negativeLimitSwitch(negLim),
      .refSwitch(refSw), .powerRemovalA(prA), .powerRemovalB(prB),
      .torqueOff(torqueOff), .loopSel(loopSel), .refValid(refValid),
      .refValue(refValue));
   // Counts one comparison and reports a mismatch
   task chk(input logic ok, input string m);
      total_checks++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Parameter access; returns at the cycle the answer stands
   task fbAcc(input logic wr, input logic [15:0] a, input logic [15:0] d);
      @(negedge sys_clk);
      fbWrEn = wr;
      fbRdEn = !wr;
      fbAddr = a;
      fbWrData = d;
      @(negedge sys_clk);
      fbWrEn = 1'b0;
      fbRdEn = 1'b0;
   endtask
   // Sends one command on fieldbus (1) or software (2), judges the grant
   task send(input logic [1:0] ch, input logic ok);
      @(negedge sys_clk);
      fbCmdValid = (ch == `DCA_OWN_FB);
      commCmdValid = (ch == `DCA_OWN_COMM);
      @(negedge sys_clk);
      fbCmdValid = 1'b0;
      commCmdValid = 1'b0;
      chk(cmdValid === ok && cmdRejected === !ok, "grant wrong");
      if (ok) chk(cmdSrc === ch && cmdOut === (ch == 1 ? fbCmd : commCmd),
                  "granted command wrong");
   endtask
   // Raises the enable pin and waits for its grant or refusal
   task pinCmd(input logic ok);
      int i;
      @(negedge sys_clk);
      sigLevel[1] = 1'b1;
      for (i = 0; i < 12 && !(cmdValid | cmdRejected); i++)
         @(negedge sys_clk);
      chk(cmdValid === ok && cmdRejected === !ok, "pin grant wrong");
      if (ok) chk(cmdSrc === `DCA_OWN_SIG, "pin source wrong");
      sigLevel[1] = 1'b0;
      repeat (8) @(negedge sys_clk);
   endtask
   task test_lock;
      chk(channelLock === 1'b0 && owner === `DCA_OWN_NONE, "reset");
      fbAcc(1, `DCA_LOCK_ADDR, 16'h0001);
      chk(fbAck === 1'b1 && channelLock === 1'b1, "lock write");
      fbAcc(0, `DCA_LOCK_ADDR, 16'h0000);
      chk(fbRdData === 16'h0001, "lock read");
      fbAcc(0, 16'h013e, 16'h0000);
      chk(fbErr === 1'b1 && fbRdData === 16'h0000, "unmapped read");
      send(`DCA_OWN_FB, 1'b1);
      send(`DCA_OWN_COMM, 1'b0);
      pinCmd(1'b0);
      sigLevel = 4'hd;
      stoOff = 1'b1;
      repeat (8) @(negedge sys_clk);
      chk(haltActive === 1'b1, "halt locked out");
      chk(posLim === 1'b1 && refSw === 1'b1 && negLim === 1'b0, "sw");
      chk(prA === 1'b1 && prB === 1'b1 && torqueOff === 1'b1, "sto");
      sigLevel = 4'h0;
      stoOff = 1'b0;
      fbAcc(1, `DCA_LOCK_ADDR, 16'hfffe);
      chk(channelLock === 1'b0, "lock release");
      nvLock = 1'b1;
      nvLoad = 1'b1;
      @(negedge sys_clk);
      nvLoad = 1'b0;
      chk(channelLock === 1'b1, "lock restore");
      fbAcc(1, `DCA_LOCK_ADDR, 16'h0000);
      chk(channelLock === 1'b0, "lock release after restore");
      $display("test lock done");
   endtask
   task test_comm;
      commAccess = 1'b1;
      repeat (2) @(negedge sys_clk);
      send(`DCA_OWN_FB, 1'b0);
      send(`DCA_OWN_COMM, 1'b1);
      pinCmd(1'b0);
      commAccess = 1'b0;
      repeat (2) @(negedge sys_clk);
      pinCmd(1'b1);
      send(`DCA_OWN_COMM, 1'b1);
      $display("test comm done");
   endtask
   task test_modes;
      dca_mode_t m;
      for (int i = 1; i <= 5; i++) begin
         m = dca_mode_t'(i);
         opMode = m;
         repeat (2) @(negedge sys_clk);
         chk(loopSel.velLoop === (m == MODE_SPEED), "loop");
         chk(loopSel.profGen === (m != MODE_SPEED), "profile");
         chk(loopSel.posLoop === (m != MODE_SPEED)
             && loopSel.modeValid === 1'b1, "position loop");
         chk(loopSel.refFieldbus === 1'b1, "ref source");
      end
      fbRef = 32'h1234abcd;
      fbRefValid = 1'b1;
      @(negedge sys_clk);
      fbRefValid = 1'b0;
      chk(refValid === 1'b1 && refValue === 32'h1234abcd, "ref");
      $display("test modes done");
   endtask
   // Cuts a hang short well past the expected run length
   initial begin
      #100000;
      bad_count++;
      $display("[ERR] %0t watchdog expired", $time);
      close_out();
   end
   initial begin
      repeat (20) @(negedge sys_clk);
      rst = 1'b0;
      repeat (8) @(negedge sys_clk);
      test_lock();
      test_comm();
      test_modes();
      close_out();
   end
endmodule // tb_top

// >>> core/dca_arbiter.sv
// Access channel arbiter of the motor drive.
// Assumes fieldbus and commissioning ports are on sys_clk;
// signal, limit and torque-off pins are asynchronous.
//
// Operation
// - Control commands come from fieldbus, commissioning software and signals.
// - An exclusive owner alone commands; other channels' commands are dropped.
// - Lock 0 releases other channels; lock 1 blocks signals and software.
// - Halt is processed even while the lock is set.
// - Signal input control functions are ignored under another owner.
// - Halt, limit and reference switch functions always stay active.
// - Both torque-off inputs act regardless of the lock.
// - Software access field grants that software exclusive control while the lock is 0.
// - Speed mode uses velocity loop; other modes position loop with profile.
// - All five modes take reference values from fieldbus commands.
`timescale 1ns/10ps
`include "dca_cfg.svh"
module dca_arbiter #(
   parameter int NPIN = 4,
   parameter int DW   = 16
) (
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   // Fieldbus parameter access
   input  wire logic                 fbWrEn,
   input  wire logic                 fbRdEn,
   input  wire logic [15:0]          fbAddr,
   input  wire logic [DW-1:0]        fbWrData,
   output logic      [DW-1:0]        fbRdData,
   output logic                      fbAck,
   output logic                      fbErr,
   // Stored lock value restored at start-up
   input  wire logic                 nvLoad,
   input  wire logic                 nvLock,
   // Fieldbus control and reference
   input  wire logic                 fbCmdValid,
   input  wire dca_pkg::dca_cmd_t    fbCmd,
   input  wire logic                 fbRefValid,
   input  wire logic [31:0]          fbRef,
   input  wire dca_pkg::dca_mode_t   opMode,
   // Commissioning software
   input  wire logic                 commAccess,
   input  wire logic                 commCmdValid,
   input  wire dca_pkg::dca_cmd_t    commCmd,
   // Configurable signal pins and their functions
   input  wire logic [NPIN-1:0]      sigPin,
   input  wire dca_pkg::dca_func_t [NPIN-1:0] sigFunc,
   input  wire logic                 safeTorqueOffA,
   input  wire logic                 safeTorqueOffB,
   // Granted command
   output logic                      cmdValid,
   output dca_pkg::dca_cmd_t         cmdOut,
   output dca_pkg::dca_owner_t       cmdSrc,
   output logic                      cmdRejected,
   output dca_pkg::dca_owner_t       owner,
   output logic                      channelLock,
   // Always-effective functions
   output logic                      haltActive,
   output logic                      positiveLimitSwitch,
   output logic                      negativeLimitSwitch,
   output logic                      refSwitch,
   output logic                      powerRemovalA,
   output logic                      powerRemovalB,
   output logic                      torqueOff,
   // Mode routing and reference
   output dca_pkg::dca_loop_t        loopSel,
   output logic                      refValid,
   output logic      [31:0]          refValue
);
   import dca_pkg::*;

   // ***************************************************
   // Function helpers
   // ***************************************************

   // Mask of pins whose assigned function equals code
   function automatic logic [NPIN-1:0] funcMask(
      input dca_func_t [NPIN-1:0] funcs,
      input dca_func_t            code
   );
      logic [NPIN-1:0] m;
      m = '0;
      for (int i = 0; i < NPIN; i++) begin
         m[i] = (funcs[i] == code);
      end
      return m;
   endfunction

   // True when a channel may command under the current owner
   function automatic logic mayCommand(
      input dca_owner_t cur,
      input dca_owner_t chan
   );
      return (cur == `DCA_OWN_NONE) || (cur == chan);
   endfunction

   // ***************************************************
   // Pin synchronisers
   // ***************************************************

   // Synchronised pin levels and their previous value
   logic [NPIN-1:0] sigSync;
   logic [1:0]      stoSync;
   logic [NPIN-1:0] sigPrev;

   // Configurable signal pins cross into sys_clk
   dca_pin_sync #(
      .W      (NPIN)
   ) u_sig_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pinIn   (sigPin),
      .pinOut  (sigSync)
   );

   // Torque-off pins cross into sys_clk
   dca_pin_sync #(
      .W      (2)
   ) u_sto_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pinIn   ({safeTorqueOffB, safeTorqueOffA}),
      .pinOut  (stoSync)
   );

   // ***************************************************
   // Channel lock parameter
   // ***************************************************

   // Decode of the single mapped parameter
   wire lockHit  = (fbAddr == `DCA_LOCK_ADDR);
   wire lockWr   = fbWrEn && lockHit;
   wire anyAcc   = fbWrEn || fbRdEn;
   wire [DW-1:0] lockWord = {{(DW-1){1'b0}}, channelLock};
   wire next_lock = lockWr ? fbWrData[`DCA_LOCK_BIT]
                  : nvLoad ? nvLock : channelLock;

   // Lock register; fieldbus write wins over a restore
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         channelLock <= `DCA_LOCK_RST;
      end else begin
         channelLock <= next_lock;
      end
   end

   // Access answer one cycle after the strobe; unmapped flags error
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fbAck    <= 1'b0;
         fbErr    <= 1'b0;
         fbRdData <= '0;
      end else begin
         fbAck    <= anyAcc && lockHit;
         fbErr    <= anyAcc && !lockHit;
         fbRdData <= (fbRdEn && lockHit) ? lockWord : '0;
      end
   end

   // ***************************************************
   // Ownership
   // ***************************************************

   // Fieldbus lock takes precedence over the software field
   wire dca_owner_t next_owner =
      channelLock ? dca_owner_t'(`DCA_OWN_FB)
      : commAccess ? dca_owner_t'(`DCA_OWN_COMM)
      : dca_owner_t'(`DCA_OWN_NONE);

   // Owner follows lock and access field one cycle later
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         owner <= `DCA_OWN_NONE;
      end else begin
         owner <= next_owner;
      end
   end

   // ***************************************************
   // Signal input commands
   // ***************************************************

   // Rising edges of synchronised pins start signal commands
   wire [NPIN-1:0] sigRise = sigSync & ~sigPrev;
   wire [NPIN-1:0] riseEn  = sigRise & funcMask(sigFunc, `DCA_FN_ENABLE);
   wire [NPIN-1:0] riseRst = sigRise & funcMask(sigFunc, `DCA_FN_FRESET);
   wire [NPIN-1:0] riseQs  = sigRise & funcMask(sigFunc, `DCA_FN_QSTOP);
   wire            sigCmdValid = |{riseEn, riseRst, riseQs};
   wire dca_cmd_t  sigCmd  =
      (|riseQs)  ? dca_cmd_t'{code: `DCA_CMD_QSTOP,  arg: 16'h0000}
      : (|riseRst) ? dca_cmd_t'{code: `DCA_CMD_FRESET, arg: 16'h0000}
      : dca_cmd_t'{code: `DCA_CMD_ENABLE, arg: 16'h0000};

   // Previous synchronised level for edge detection
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sigPrev <= '0;
      end else begin
         sigPrev <= sigSync;
      end
   end

   // ***************************************************
   // Command arbitration
   // ***************************************************

   // Grant by owner, then fieldbus over software over signals
   wire fbOk = fbCmdValid && mayCommand(owner, `DCA_OWN_FB);
   wire cmOk = commCmdValid
            && mayCommand(owner, `DCA_OWN_COMM);
   wire sgOk = sigCmdValid
            && (owner == `DCA_OWN_NONE);
   wire fbGo = fbOk;
   wire cmGo = cmOk && !fbOk;
   wire sgGo = sgOk && !fbOk && !cmOk;
   wire anyGo = fbGo || cmGo || sgGo;
   wire dca_cmd_t next_cmd = fbGo ? fbCmd
                           : cmGo ? commCmd : sigCmd;
   wire dca_owner_t next_src =
      fbGo ? dca_owner_t'(`DCA_OWN_FB)
      : cmGo ? dca_owner_t'(`DCA_OWN_COMM)
      : dca_owner_t'(`DCA_OWN_SIG);
   // Losers of arbitration are reported as rejected
   wire next_rej = (fbCmdValid && !fbGo)
                || (commCmdValid && !cmGo)
                || (sigCmdValid && !sgGo);

   // Granted command stands one cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cmdValid    <= 1'b0;
         cmdOut      <= '0;
         cmdSrc      <= `DCA_OWN_NONE;
         cmdRejected <= 1'b0;
      end else begin
         cmdValid    <= anyGo;
         cmdOut      <= anyGo ? next_cmd : '0;
         cmdSrc      <= anyGo ? next_src : dca_owner_t'(`DCA_OWN_NONE);
         cmdRejected <= next_rej;
      end
   end

   // ***************************************************
   // Always-effective functions
   // ***************************************************

   // Never gated by owner or lock
   wire next_halt = |(sigSync & funcMask(sigFunc, `DCA_FN_HALT));
   wire next_positive_limit_switch = |(sigSync & funcMask(sigFunc, `DCA_FN_POSITIVE_LIMIT_SWITCH));
   wire next_negative_limit_switch = |(sigSync & funcMask(sigFunc, `DCA_FN_NEGATIVE_LIMIT_SWITCH));
   wire next_refs = |(sigSync & funcMask(sigFunc, `DCA_FN_REF));
   // Low level on a torque-off input removes power
   wire next_prA  = !stoSync[0];
   wire next_prB  = !stoSync[1];

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         haltActive          <= 1'b0;
         positiveLimitSwitch <= 1'b0;
         negativeLimitSwitch <= 1'b0;
         refSwitch           <= 1'b0;
         powerRemovalA       <= 1'b1;
         powerRemovalB       <= 1'b1;
         torqueOff           <= 1'b1;
      end else begin
         haltActive          <= next_halt;
         positiveLimitSwitch <= next_positive_limit_switch;
         negativeLimitSwitch <= next_negative_limit_switch;
         refSwitch           <= next_refs;
         powerRemovalA       <= next_prA;
         powerRemovalB       <= next_prB;
         torqueOff           <= next_prA || next_prB;
      end
   end

   // ***************************************************
   // Mode routing and reference values
   // ***************************************************

   // Mode decides loop and profile generator use
   dca_mode_map u_mode_map (
      .sys_clk (sys_clk),
      .rst     (rst),
      .mode    (opMode),
      .loopSel (loopSel)
   );

   // Reference values only come from the fieldbus in a valid mode
   wire next_refValid = fbRefValid && loopSel.refFieldbus;

   // Last accepted reference is held between updates
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         refValid <= 1'b0;
         refValue <= '0;
      end else begin
         refValid <= next_refValid;
         if (next_refValid) begin
            refValue <= fbRef;
         end
      end
   end
endmodule // dca_arbiter

// >>> core/dca_cfg.svh
// Named constants of the drive access channel arbiter.
// Assumes inclusion by the package and design files by bare name.
`ifndef DCA_CFG_SVH
`define DCA_CFG_SVH
// Fieldbus parameter address of the channel lock
`define DCA_LOCK_ADDR    16'h013c
`define DCA_LOCK_RST     1'b0
`define DCA_LOCK_BIT     0
// Operating mode codes
`define DCA_MODE_NONE    3'h0
`define DCA_MODE_JOG     3'h1
`define DCA_MODE_SPEED   3'h2
`define DCA_MODE_PPOS    3'h3
`define DCA_MODE_PVEL    3'h4
`define DCA_MODE_HOME    3'h5
// Signal input function codes
`define DCA_FN_NONE      3'h0
`define DCA_FN_ENABLE    3'h1
`define DCA_FN_FRESET    3'h2
`define DCA_FN_QSTOP     3'h3
`define DCA_FN_HALT      3'h4
`define DCA_FN_POSITIVE_LIMIT_SWITCH      3'h5
`define DCA_FN_NEGATIVE_LIMIT_SWITCH      3'h6
`define DCA_FN_REF       3'h7
// Control command codes
`define DCA_CMD_NONE     4'h0
`define DCA_CMD_ENABLE   4'h1
`define DCA_CMD_FRESET   4'h2
`define DCA_CMD_QSTOP    4'h3
// Channel owner codes
`define DCA_OWN_NONE     2'h0
`define DCA_OWN_FB       2'h1
`define DCA_OWN_COMM     2'h2
`define DCA_OWN_SIG      2'h3
`endif

// >>> core/dca_mode_map.sv
// Maps the operating mode to control loop and profile generator use.
// Assumes mode comes from logic on sys_clk.
`timescale 1ns/10ps
module dca_mode_map (
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   input  wire dca_pkg::dca_mode_t   mode,
   output dca_pkg::dca_loop_t        loopSel
);
   import dca_pkg::*;
   dca_loop_t next_loopSel;

   // Speed mode runs the velocity loop without profile generator
   always_comb begin
      next_loopSel = '0;
      case (mode)
         MODE_SPEED: begin
            next_loopSel.velLoop     = 1'b1;
            next_loopSel.refFieldbus = 1'b1;
            next_loopSel.modeValid   = 1'b1;
         end
         MODE_JOG, MODE_PPOS, MODE_PVEL, MODE_HOME: begin
            next_loopSel.posLoop     = 1'b1;
            next_loopSel.profGen     = 1'b1;
            next_loopSel.refFieldbus = 1'b1;
            next_loopSel.modeValid   = 1'b1;
         end
         default: next_loopSel = '0;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         loopSel <= '0;
      end else begin
         loopSel <= next_loopSel;
      end
   end
endmodule // dca_mode_map

// >>> core/dca_pin_sync.sv
// Three-stage synchroniser for a group of pin inputs.
// Assumes pins are asynchronous to sys_clk; settled level out.
`timescale 1ns/10ps
module dca_pin_sync #(
   parameter int W = 4
) (
   input  wire logic         sys_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] pinIn,
   output logic      [W-1:0] pinOut
);
   logic [W-1:0] ff1;
   logic [W-1:0] ff2;
   logic [W-1:0] ff3;
   wire  [W-1:0] agree = ~(ff2 ^ ff3);
   wire  [W-1:0] next_pinOut = (pinOut & ~agree) | (ff3 & agree);

   // Shift chain; output follows once stages two and three agree
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ff1    <= '0;
         ff2    <= '0;
         ff3    <= '0;
         pinOut <= '0;
      end else begin
         ff1    <= pinIn;
         ff2    <= ff1;
         ff3    <= ff2;
         pinOut <= next_pinOut;
      end
   end
endmodule // dca_pin_sync

// >>> core/dca_pkg.sv
// Types shared by the access channel arbiter files.
// Assumes dca_cfg.svh is on the include path.
`include "dca_cfg.svh"
package dca_pkg;
   typedef enum logic [2:0] {
      MODE_NONE  = `DCA_MODE_NONE,
      MODE_JOG   = `DCA_MODE_JOG,
      MODE_SPEED = `DCA_MODE_SPEED,
      MODE_PPOS  = `DCA_MODE_PPOS,
      MODE_PVEL  = `DCA_MODE_PVEL,
      MODE_HOME  = `DCA_MODE_HOME
   } dca_mode_t;
   typedef logic [2:0] dca_func_t;
   typedef logic [1:0] dca_owner_t;
   typedef struct packed {
      logic [3:0]  code;
      logic [15:0] arg;
   } dca_cmd_t;
   typedef struct packed {
      logic velLoop;
      logic posLoop;
      logic profGen;
      logic refFieldbus;
      logic modeValid;
   } dca_loop_t;
endpackage : dca_pkg
